//--- hdl/bcp_pkg.sv
/*
 * Shared constants of the bias controller register bank: register select
 * codes, field positions, reset values and the FIFO channel tag codes.
 * Assumes a serial front end that decodes frames into register accesses.
 */
package bcp_pkg;

    // ------------------------------------------------------------------
    // Register select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_POWER_DOWN = 2'h0;
    localparam logic [1:0] SEL_DAC_LOAD   = 2'h1;
    localparam logic [1:0] SEL_MESSAGE    = 2'h2;
    localparam logic [1:0] SEL_FIFO_READ  = 2'h3;

    // ------------------------------------------------------------------
    // Power-down control fields
    // ------------------------------------------------------------------
    localparam int PD_SLEEP_BIT    = 5;
    localparam int PD_REF_ON_BIT   = 4;
    localparam int PD_WDOG_OFF_BIT = 3;
    localparam int PD_OSC_OFF_BIT  = 2;
    localparam int PD_CH2_OFF_BIT  = 1;
    localparam int PD_CH1_OFF_BIT  = 0;
    localparam int PD_WIDTH        = 6;
    localparam logic [PD_WIDTH-1:0] PD_RESET = 6'h03;

    // ------------------------------------------------------------------
    // Load command and message fields
    // ------------------------------------------------------------------
    localparam int LD_CH2_BIT   = 1;
    localparam int LD_CH1_BIT   = 0;
    localparam int MSG_LEN_LSB  = 8;
    localparam int FIELD_W      = 8;
    localparam logic [FIELD_W-1:0] MSG_FIELD_RESET = 8'h00;

    // ------------------------------------------------------------------
    // FIFO word layout and tags
    // ------------------------------------------------------------------
    localparam int DATA_W  = 12;
    localparam int TAG_W   = 4;
    localparam int WORD_W  = 16;
    localparam logic [TAG_W-1:0] TAG_AVG_BASE = 4'h8;
    localparam logic [TAG_W-1:0] TAG_ERROR    = 4'he;
    localparam logic [TAG_W-1:0] TAG_EMPTY    = 4'hf;

    typedef enum logic [1:0] {
        BCP_SRC_STREAM,
        BCP_SRC_ADC,
        BCP_SRC_AVG,
        BCP_SRC_ERROR
    } bcp_src_kind_t;

endpackage

//--- hdl/bcp_regs.sv
/*
 * Register bank of the dual-channel bias controller: power-down control,
 * DAC load command, message read setup and the tagged FIFO read port with
 * a two-entry buffer in front of it.
 * Assumes a serial front end presenting one-cycle read and write strobes
 * with a register select, and producers synchronous to sys_clk.
 */
`timescale 1ns/1ps

// Overview of operation
// - Power-down bit five shuts every section; clearing it wakes; resets zero.
// - Reference-keep-on holds reference powered unless asleep; else only during conversions.
// - Watchdog oscillator off bit stops the watchdog oscillator; resets zero.
// - Main oscillator off bit stops the internal oscillator; resets zero.
// - Channel converter off bits power down DAC and amplifier; reset one.
// - Load bit copies that channel's input register into its output register.
// - Message length field plus one gives words read; resets zero.
// - Message address field gives the starting memory word; resets zero.
// - FIFO word: data in low twelve bits, tag or upper data above.
// - ADC monitoring tags samples by source codes zero through six.
// - Averaging monitor tags averages with codes eight through eleven.
// - Tag fourteen marks a word whose data may be corrupted.
// - Read of empty FIFO returns tag fifteen with flag register value.
// - Empty flag is one with no data, zero once a word enters.
module bcp_regs
    import bcp_pkg::*;
#(
    parameter int DATA_BITS = 12
) (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [1:0]           reg_sel,
    input  wire logic [WORD_W-1:0]    reg_wdata,
    output logic      [WORD_W-1:0]    reg_rdata,
    output logic                      reg_rvalid,
    input  wire logic                 adc_conv_active,
    input  wire logic                 adc_monitor_enable,
    input  wire logic                 average_monitor_enable,
    input  wire logic [DATA_BITS-1:0] flag_value,
    input  wire logic [DATA_BITS-1:0] ch1_dac_input,
    input  wire logic [DATA_BITS-1:0] ch2_dac_input,
    output logic      [DATA_BITS-1:0] ch1_dac_output,
    output logic      [DATA_BITS-1:0] ch2_dac_output,
    output logic                      whole_part_sleep,
    output logic                      reference_on,
    output logic                      watchdog_osc_run,
    output logic                      main_osc_run,
    output logic                      ch1_converter_off,
    output logic                      ch2_converter_off,
    output logic      [FIELD_W-1:0]   message_length,
    output logic      [FIELD_W-1:0]   message_start_addr,
    output logic      [FIELD_W:0]     message_word_count,
    output logic                      message_start,
    input  wire logic                 src_valid,
    output logic                      src_ready,
    input  wire logic [1:0]           src_kind,
    input  wire logic [2:0]           src_index,
    input  wire logic [WORD_W-1:0]    src_word,
    output logic                      queue_empty_flag
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [PD_WIDTH-1:0] pd_reg;
    logic [FIELD_W-1:0]  msg_len_reg;
    logic [FIELD_W-1:0]  msg_addr_reg;
    logic [DATA_BITS-1:0] ch1_out_reg;
    logic [DATA_BITS-1:0] ch2_out_reg;
    logic                 msg_start_reg;
    logic [WORD_W-1:0]    rdata_reg;
    logic                 rvalid_reg;

    logic                 wr_pd;
    logic                 wr_ld;
    logic                 wr_msg;
    logic                 rd_any;
    logic                 rd_fifo;

    assign wr_pd   = reg_wr && (reg_sel == SEL_POWER_DOWN);
    assign wr_ld   = reg_wr && (reg_sel == SEL_DAC_LOAD);
    assign wr_msg  = reg_wr && (reg_sel == SEL_MESSAGE);
    assign rd_any  = reg_rd;
    assign rd_fifo = reg_rd && (reg_sel == SEL_FIFO_READ);

    // ------------------------------------------------------------------
    // Power-down control
    // ------------------------------------------------------------------
    // Unused bits dropped.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pd_reg <= PD_RESET;
        end else if (wr_pd) begin
            pd_reg <= reg_wdata[PD_WIDTH-1:0];
        end
    end

    // Outputs are registered so the analog enables never glitch when the
    // keep-on bit and the conversion request change in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            whole_part_sleep  <= 1'b0;
            reference_on      <= 1'b0;
            watchdog_osc_run  <= 1'b1;
            main_osc_run      <= 1'b1;
            ch1_converter_off <= 1'b1;
            ch2_converter_off <= 1'b1;
        end else begin
            whole_part_sleep  <= pd_reg[PD_SLEEP_BIT];
            reference_on      <= !pd_reg[PD_SLEEP_BIT] &&
                                 (pd_reg[PD_REF_ON_BIT] || adc_conv_active);
            watchdog_osc_run  <= !pd_reg[PD_SLEEP_BIT] &&
                                 !pd_reg[PD_WDOG_OFF_BIT];
            main_osc_run      <= !pd_reg[PD_SLEEP_BIT] &&
                                 !pd_reg[PD_OSC_OFF_BIT];
            ch1_converter_off <= pd_reg[PD_SLEEP_BIT] ||
                                 pd_reg[PD_CH1_OFF_BIT];
            ch2_converter_off <= pd_reg[PD_SLEEP_BIT] ||
                                 pd_reg[PD_CH2_OFF_BIT];
        end
    end

    // ------------------------------------------------------------------
    // DAC load command
    // ------------------------------------------------------------------
    // One-shot input copy; nothing of the command is kept.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ch1_out_reg <= '0;
            ch2_out_reg <= '0;
        end else begin
            if (wr_ld && reg_wdata[LD_CH1_BIT]) begin
                ch1_out_reg <= ch1_dac_input;
            end
            if (wr_ld && reg_wdata[LD_CH2_BIT]) begin
                ch2_out_reg <= ch2_dac_input;
            end
        end
    end

    assign ch1_dac_output = ch1_out_reg;
    assign ch2_dac_output = ch2_out_reg;

    // ------------------------------------------------------------------
    // Message read setup
    // ------------------------------------------------------------------
    // Length field store.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            msg_len_reg        <= MSG_FIELD_RESET;
            msg_addr_reg       <= MSG_FIELD_RESET;
            message_word_count <= {1'b0, MSG_FIELD_RESET} + 9'h001;
            msg_start_reg      <= 1'b0;
        end else begin
            msg_start_reg <= wr_msg;
            if (wr_msg) begin
                msg_len_reg        <= reg_wdata[MSG_LEN_LSB +: FIELD_W];
                msg_addr_reg       <= reg_wdata[FIELD_W-1:0];
                // Words read is length plus one.
                message_word_count <= {1'b0,
                                       reg_wdata[MSG_LEN_LSB +: FIELD_W]}
                                      + 9'h001;
            end
        end
    end

    assign message_length     = msg_len_reg;
    assign message_start_addr = msg_addr_reg;
    assign message_start      = msg_start_reg;

    // ------------------------------------------------------------------
    // Tagging of incoming words
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] tagged_word;
    logic              src_keep;

    always_comb begin
        tagged_word = src_word;
        src_keep    = 1'b1;
        unique case (bcp_src_kind_t'(src_kind))
            BCP_SRC_STREAM: begin
                tagged_word = src_word;
            end
            BCP_SRC_ADC: begin
                tagged_word = {1'b0, src_index, src_word[DATA_W-1:0]};
                src_keep    = adc_monitor_enable;
            end
            BCP_SRC_AVG: begin
                tagged_word = {TAG_AVG_BASE | {2'b00, src_index[1:0]},
                               src_word[DATA_W-1:0]};
                src_keep    = average_monitor_enable;
            end
            BCP_SRC_ERROR: begin
                tagged_word = {TAG_ERROR, src_word[DATA_W-1:0]};
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Two-entry buffer
    // ------------------------------------------------------------------
    // Words whose monitor bit is clear are accepted and dropped, so a
    // producer of a mode that the host has turned off stalls only while the buffer holds two words.
    logic [WORD_W-1:0] buf_mem [2];
    logic              wr_ptr_reg;
    logic              rd_ptr_reg;
    logic [1:0]        count_reg;
    logic [1:0]        count_next;
    logic              push;
    logic              pop;

    assign src_ready  = (count_reg != 2'h2);
    assign push       = src_valid && src_ready && src_keep;
    assign pop        = rd_fifo && (count_reg != 2'h0);
    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge sys_clk) begin
        if (push) begin
            buf_mem[wr_ptr_reg] <= tagged_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg  <= count_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            queue_empty_flag <= 1'b1;
        end else begin
            queue_empty_flag <= (count_next == 2'h0);
        end
    end

    // ------------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] rdata_next;

    always_comb begin
        rdata_next = '0;
        unique case (reg_sel)
            SEL_POWER_DOWN: begin
                rdata_next = {{(WORD_W-PD_WIDTH){1'b0}}, pd_reg};
            end
            SEL_DAC_LOAD: begin
                rdata_next = '0;
            end
            SEL_MESSAGE: begin
                rdata_next = {msg_len_reg, msg_addr_reg};
            end
            SEL_FIFO_READ: begin
                if (count_reg == 2'h0) begin
                    rdata_next = {TAG_EMPTY, flag_value[DATA_W-1:0]};
                end else begin
                    rdata_next = buf_mem[rd_ptr_reg];
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rd_any;
            if (rd_any) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;

endmodule

//--- dv/bcp_regs_checker.sv
/* Port assertions for the bias controller register bank.
   Assumes it is bound into bcp_regs and sees only its ports. */
`timescale 1ns/1ps
module bcp_regs_checker
    import bcp_pkg::*;
#(
    parameter int DATA_BITS = 12
) (
    input wire logic                 sys_clk,
    input wire logic                 sys_rst,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [1:0]           reg_sel,
    input wire logic [WORD_W-1:0]    reg_wdata,
    input wire logic [WORD_W-1:0]    reg_rdata,
    input wire logic                 reg_rvalid,
    input wire logic [DATA_BITS-1:0] flag_value,
    input wire logic [DATA_BITS-1:0] ch1_dac_input,
    input wire logic [DATA_BITS-1:0] ch1_dac_output,
    input wire logic                 whole_part_sleep,
    input wire logic                 reference_on,
    input wire logic                 ch1_converter_off,
    input wire logic [FIELD_W-1:0]   message_length,
    input wire logic [FIELD_W-1:0]   message_start_addr,
    input wire logic [FIELD_W:0]     message_word_count,
    input wire logic                 src_valid,
    input wire logic                 src_ready,
    input wire logic [1:0]           src_kind,
    input wire logic                 queue_empty_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire fifo_rd = reg_rd && reg_sel == SEL_FIFO_READ;

    // Register write first, power outputs follow one edge later.
    sequence s_pd_wr;
        reg_wr && reg_sel == SEL_POWER_DOWN;
    endsequence

    AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered next cycle");
    AST_SLEEP_WRITE: assert property (s_pd_wr |=> ##1
        whole_part_sleep == $past(reg_wdata[PD_SLEEP_BIT], 2))
        else $error("sleep output does not follow write");
    AST_SLEEP_ALL: assert property (whole_part_sleep |->
        !reference_on && ch1_converter_off)
        else $error("section left powered in sleep");
    AST_LOAD_CH1: assert property (reg_wr && reg_sel == SEL_DAC_LOAD
        |=> ch1_dac_output == ($past(reg_wdata[LD_CH1_BIT]) ?
        $past(ch1_dac_input) : $past(ch1_dac_output)))
        else $error("channel one load wrong");
    AST_MSG_FIELDS: assert property (reg_wr && reg_sel == SEL_MESSAGE
        |=> {message_length, message_start_addr} == $past(reg_wdata))
        else $error("message fields not written");
    AST_MSG_COUNT: assert property ($stable(message_length) |->
        message_word_count == {1'b0, message_length} + 9'h001)
        else $error("word count not length plus one");
    AST_EMPTY_READ: assert property (fifo_rd && queue_empty_flag
        && !src_valid |=> reg_rdata == {TAG_EMPTY, $past(flag_value)})
        else $error("empty read lacks empty tag");
    AST_PUSH_FLAG: assert property (src_valid && src_ready &&
        src_kind == BCP_SRC_STREAM && !fifo_rd |=> !queue_empty_flag)
        else $error("empty flag stays high after push");
endmodule

bind bcp_regs bcp_regs_checker #(.DATA_BITS(DATA_BITS)) chk_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .flag_value(flag_value), .ch1_dac_input(ch1_dac_input),
    .ch1_dac_output(ch1_dac_output), .reference_on(reference_on),
    .whole_part_sleep(whole_part_sleep),
    .ch1_converter_off(ch1_converter_off),
    .message_length(message_length),
    .message_start_addr(message_start_addr),
    .message_word_count(message_word_count), .src_valid(src_valid),
    .src_ready(src_ready), .src_kind(src_kind),
    .queue_empty_flag(queue_empty_flag));

//--- dv/bcp_src_model.sv
/* Producer model feeding words into the register bank buffer.
   Assumes the bench calls push and the bank drives src_ready. */
`timescale 1ns/1ps
module bcp_src_model
    import bcp_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         src_ready,
    output logic              src_valid,
    output logic [1:0]        src_kind,
    output logic [2:0]        src_index,
    output logic [WORD_W-1:0] src_word
);
    initial begin
        src_valid = 1'b0;
        src_kind = 2'h0;
        src_index = 3'h0;
        src_word = 16'h0000;
    end

    // Idle word is inverted so a stale value is never mistaken for data.
    task automatic push(input logic [1:0] kind, input logic [2:0] idx,
                        input logic [WORD_W-1:0] word, output bit ok);
        ok = 1'b0;
        @(negedge sys_clk);
        src_valid = 1'b1;
        src_kind = kind;
        src_index = idx;
        src_word = word;
        // Ready is only looked at on the falling edge, where it is settled,
        // so an accepting edge is never missed and no word is sent twice.
        for (int n = 0; n < 50 && !ok; n++) begin
            ok = (src_ready === 1'b1);
            @(posedge sys_clk);
            if (!ok) begin
                @(negedge sys_clk);
            end
        end
        @(negedge sys_clk);
        src_valid = 1'b0;
        src_word = ~word;
        src_index = ~idx;
    endtask
endmodule

//--- dv/tb_bcp_regs.sv
/* Bench for the register bank: bus tasks, tables, tagged checks.
   Assumes bcp_regs, its bound checker and bcp_src_model. */
`timescale 1ns/1ps
module tb_bcp_regs
    import bcp_pkg::*;
;
    logic        sys_clk, sys_rst, reg_wr, reg_rd, adc_conv, adc_mon, avg_mon;
    logic        rvalid, src_valid, src_ready, q_empty, msg_start;
    logic [1:0]  reg_sel, src_kind, kind;
    logic [2:0]  src_index;
    logic [3:0]  tag;
    logic [11:0] flag_value, ch1_in, ch2_in, ch1_out, ch2_out;
    logic [15:0] reg_wdata, rdata, src_word, w;
    wire  [5:0]  pwr;
    wire  [8:0]  msg_cnt;
    wire  [15:0] msg;
    int          err_total, total_checks;
    bit          ok;
    logic [15:0] pd_wr [4] = '{16'hffdc, 16'h0020, 16'h000a, 16'h0003};
    logic [5:0]  pd_out [4] = '{6'h10, 6'h23, 6'h06, 6'h0f};

    bcp_regs dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .reg_rdata(rdata), .reg_rvalid(rvalid),
        .adc_conv_active(adc_conv), .adc_monitor_enable(adc_mon),
        .average_monitor_enable(avg_mon), .flag_value(flag_value),
        .ch1_dac_input(ch1_in), .ch2_dac_input(ch2_in),
        .ch1_dac_output(ch1_out), .ch2_dac_output(ch2_out),
        .whole_part_sleep(pwr[5]), .reference_on(pwr[4]),
        .watchdog_osc_run(pwr[3]), .main_osc_run(pwr[2]),
        .ch2_converter_off(pwr[1]), .ch1_converter_off(pwr[0]),
        .message_length(msg[15:8]), .message_start_addr(msg[7:0]),
        .message_word_count(msg_cnt), .message_start(msg_start),
        .src_valid(src_valid), .src_ready(src_ready),
        .src_kind(src_kind), .src_index(src_index),
        .src_word(src_word), .queue_empty_flag(q_empty));
    bcp_src_model src_u (
        .sys_clk(sys_clk), .src_ready(src_ready), .src_valid(src_valid),
        .src_kind(src_kind), .src_index(src_index), .src_word(src_word));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string nm, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches",
                 total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [1:0] sel, input logic [15:0] e);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_sel = sel;
        // The answer stands for one cycle after the taking edge.
        @(negedge sys_clk);
        check("rvalid", 16'h0001, {15'h0, rvalid});
        check("rdata", e, rdata);
        reg_rd = 1'b0;
    endtask
    // A producer that is never accepted ends the run as a mismatch.
    task automatic put(input logic [1:0] k, input logic [2:0] i,
                       input logic [15:0] d);
        src_u.push(k, i, d, ok);
        if (!ok) begin
            err_total++;
            end_of_test();
        end
    endtask

    initial begin
        {reg_wr, reg_rd, adc_conv, adc_mon, avg_mon, reg_sel} = '0;
        {reg_wdata, flag_value, ch1_in, ch2_in} = '0;
        sys_rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        check("reset power", 16'h000f, {10'h0, pwr});
        check("reset count", 16'h0001, {7'h0, msg_cnt});
        check("reset empty", 16'h0001, {15'h0, q_empty});
        rd(SEL_MESSAGE, 16'h0000);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(SEL_POWER_DOWN, pd_wr[i]);
            rd(SEL_POWER_DOWN, {10'h0, pd_wr[i][5:0]});
            check("power", {10'h0, pd_out[i]}, {10'h0, pwr});
        end
        adc_conv = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("ref conv", 16'h0001, {15'h0, pwr[4]});
        adc_conv = 1'b0;
        $display("Test power done");
        ch1_in = 12'h5a5;
        ch2_in = 12'h3c3;
        wr(SEL_DAC_LOAD, 16'hfffd);
        check("ch1 out", 16'h05a5, {4'h0, ch1_out});
        check("ch2 out", 16'h0000, {4'h0, ch2_out});
        ch1_in = 12'h111;
        ch2_in = 12'h222;
        wr(SEL_DAC_LOAD, 16'h0002);
        check("ch1 held", 16'h05a5, {4'h0, ch1_out});
        check("ch2 out", 16'h0222, {4'h0, ch2_out});
        rd(SEL_DAC_LOAD, 16'h0000);
        foreach (pd_wr[i]) begin
            wr(SEL_MESSAGE, pd_wr[i]);
            check("start", 16'h0001, {15'h0, msg_start});
            check("fields", pd_wr[i], msg);
            rd(SEL_MESSAGE, pd_wr[i]);
            check("start low", 16'h0000, {15'h0, msg_start});
            check("count", {8'h0, pd_wr[i][15:8]} + 16'h1,
                  {7'h0, msg_cnt});
        end
        $display("Test load and message done");
        flag_value = 12'habc;
        adc_mon = 1'b1;
        avg_mon = 1'b1;
        rd(SEL_FIFO_READ, 16'hfabc);
        put(BCP_SRC_STREAM, 3'h0, 16'h9123);
        put(BCP_SRC_ADC, 3'h5, 16'hf777);
        check("empty", 16'h0000, {15'h0, q_empty});
        check("full stall", 16'h0000, {15'h0, src_ready});
        rd(SEL_FIFO_READ, 16'h9123);
        rd(SEL_FIFO_READ, 16'h5777);
        rd(SEL_FIFO_READ, 16'hfabc);
        for (int i = 0; i < 12; i++) begin
            kind = (i < 7) ? 2'h1 : (i < 11) ? 2'h2 : 2'h3;
            tag = (i < 7) ? 4'(i) : (i < 11) ? 4'(i + 1) : 4'he;
            w = 16'h5a00 + 16'(i);
            put(kind, (i < 7) ? 3'(i) : 3'(i - 7), w);
            rd(SEL_FIFO_READ, {tag, w[11:0]});
        end
        adc_mon = 1'b0;
        avg_mon = 1'b0;
        put(BCP_SRC_ADC, 3'h1, 16'h1234);
        put(BCP_SRC_AVG, 3'h1, 16'h4321);
        rd(SEL_FIFO_READ, 16'hfabc);
        $display("Test fifo done");
        end_of_test();
    end
endmodule
